// ==== core/ibx_exec.sv ====
/*
  Execution unit for loop-decrement, increment, bit/carry/accumulator branches and indexed jump.
  Assumes the datapath presents operand byte and bit both as pin and as output latch, with a
  flag telling whether the operand is a port; results come back one cycle after req_valid.
*/
// Notes on behaviour
// RL1: loop decrement subtracts one, wraps, branches if result nonzero, flags untouched.
// RL2: byte increment adds one, rolls over to zero, changes no flags.
// RL3: increment accepts bank register, direct and pointer-register indirect encodings.
// RL4: increment of a port reads the output latch, not pins.
// RL5: data pointer increments as one 16-bit value, no flags changed.
// RL6: two-byte branches add two, then displacement when condition holds.
// RL7: three-byte bit branches add three, then third-byte displacement when taken.
// RL8: branch-if-bit-set branches on one, leaves bit and flags alone.
// RL9: branch-and-clear clears bit and branches only when bit is one.
// RL10: bit tests on port bits sample the output latch.
// RL11: branch-if-bit-clear branches on zero, leaves bit and flags alone.
// RL12: branch-on-carry branches only when carry is one.
// RL13: branch-on-no-carry branches only when carry is zero, carry untouched.
// RL14: accumulator-nonzero branch branches if any bit set, accumulator kept.
// RL15: indexed jump loads accumulator plus data pointer, modulo 2^16.
// RL16: relative targets wrap in 16 bits, displacement signed -128 to +127.
`timescale 1ns/10ps
module ibx_exec #(
  parameter logic [7:0] OPC_INC_DP = 8'hA3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc,
  input wire logic [7:0] operand_pin,
  input wire logic [7:0] operand_latch,
  input wire logic operand_is_port,
  input wire logic bit_pin,
  input wire logic bit_latch,
  input wire logic bit_is_port,
  input wire logic carry,
  input wire logic [7:0] acc,
  input wire logic [15:0] data_pointer16,
  output logic done,
  output logic unsupported,
  output logic taken,
  output logic [15:0] pc_new,
  output logic [7:0] wb_byte,
  output logic wb_byte_en,
  output logic wb_bit_clear,
  output logic [15:0] data_pointer16_new,
  output logic data_pointer16_wr
);

  typedef struct packed {
    logic done;
    logic unsupported;
    logic taken;
    logic [15:0] pc_new;
    logic [7:0] wb_byte;
    logic wb_byte_en;
    logic wb_bit_clear;
    logic [15:0] data_pointer16_new;
    logic data_pointer16_wr;
  } ibx_state_t;

  ibx_state_t s_q;
  ibx_state_t s_d;
  ibx_pkg::ibx_op_t op;
  logic [7:0] rmw_byte;
  logic [7:0] dec_byte;
  logic [7:0] inc_byte;
  logic bit_val;
  logic cond;

  ibx_rel_if rel ();

  ibx_reltgt u_reltgt (
    .rel(rel.adder)
  );

  // operation decode
  always_comb begin
    op = ibx_pkg::IBX_OP_NONE;
    if ((opcode & ibx_pkg::MSK_REG) == ibx_pkg::PAT_DEC_BR_REG) begin
      op = ibx_pkg::IBX_OP_DEC_BR2;
    end else if (opcode == ibx_pkg::OPC_DEC_BR_DIR) begin
      op = ibx_pkg::IBX_OP_DEC_BR3;
    end else if ((opcode & ibx_pkg::MSK_REG) == ibx_pkg::PAT_INC_REG ||
                 (opcode & ibx_pkg::MSK_PTR) == ibx_pkg::PAT_INC_PTR ||
                 opcode == ibx_pkg::OPC_INC_DIR) begin
      op = ibx_pkg::IBX_OP_INC; // RL3
    end else if (opcode == OPC_INC_DP) begin
      op = ibx_pkg::IBX_OP_INC_DP;
    end else begin
      case (opcode)
        ibx_pkg::OPC_BR_BIT_SET: op = ibx_pkg::IBX_OP_BR_SET;
        ibx_pkg::OPC_BR_CLR_BIT: op = ibx_pkg::IBX_OP_BR_CLR_BIT;
        ibx_pkg::OPC_BR_BIT_CLEAR: op = ibx_pkg::IBX_OP_BR_NSET;
        ibx_pkg::OPC_BR_CARRY: op = ibx_pkg::IBX_OP_BR_C;
        ibx_pkg::OPC_BR_NO_CARRY: op = ibx_pkg::IBX_OP_BR_NC;
        ibx_pkg::OPC_BR_ACC_NZ: op = ibx_pkg::IBX_OP_BR_NZ;
        ibx_pkg::OPC_JMP_IDX: op = ibx_pkg::IBX_OP_JMP;
        default: op = ibx_pkg::IBX_OP_NONE;
      endcase
    end
  end

  // operand selection and arithmetic
  always_comb begin
    rmw_byte = operand_is_port ? operand_latch : operand_pin; // RL4
    bit_val = bit_is_port ? bit_latch : bit_pin; // RL10
    dec_byte = rmw_byte - ibx_pkg::BYTE_ONE; // RL1
    inc_byte = rmw_byte + ibx_pkg::BYTE_ONE; // RL2
  end

  // branch condition and relative adder inputs
  always_comb begin
    cond = 1'b0;
    rel.len = ibx_pkg::LEN_ONE;
    rel.disp = byte2;
    case (op)
      ibx_pkg::IBX_OP_DEC_BR2: begin
        cond = dec_byte != ibx_pkg::BYTE_ZERO; // RL1
        rel.len = ibx_pkg::LEN_TWO;
      end
      ibx_pkg::IBX_OP_DEC_BR3: begin
        cond = dec_byte != ibx_pkg::BYTE_ZERO; // RL1
        rel.len = ibx_pkg::LEN_THREE;
        rel.disp = byte3;
      end
      ibx_pkg::IBX_OP_INC: begin
        rel.len = (opcode == ibx_pkg::OPC_INC_DIR) ? ibx_pkg::LEN_TWO : ibx_pkg::LEN_ONE;
      end
      ibx_pkg::IBX_OP_BR_SET: begin
        cond = bit_val; // RL8
        rel.len = ibx_pkg::LEN_THREE; // RL7
        rel.disp = byte3;
      end
      ibx_pkg::IBX_OP_BR_CLR_BIT: begin
        cond = bit_val; // RL9
        rel.len = ibx_pkg::LEN_THREE; // RL7
        rel.disp = byte3;
      end
      ibx_pkg::IBX_OP_BR_NSET: begin
        cond = !bit_val; // RL11
        rel.len = ibx_pkg::LEN_THREE; // RL7
        rel.disp = byte3;
      end
      ibx_pkg::IBX_OP_BR_C: begin
        cond = carry; // RL12
        rel.len = ibx_pkg::LEN_TWO; // RL6
      end
      ibx_pkg::IBX_OP_BR_NC: begin
        cond = !carry; // RL13
        rel.len = ibx_pkg::LEN_TWO; // RL6
      end
      ibx_pkg::IBX_OP_BR_NZ: begin
        cond = acc != ibx_pkg::BYTE_ZERO; // RL14
        rel.len = ibx_pkg::LEN_TWO; // RL6
      end
      default: cond = 1'b0;
    endcase
    rel.pc_base = pc;
    rel.take = cond;
  end

  // next state; flags are never written by this unit
  always_comb begin
    s_d = s_q;
    s_d.done = req_valid;
    s_d.unsupported = 1'b0;
    s_d.taken = 1'b0;
    s_d.wb_byte_en = 1'b0;
    s_d.wb_bit_clear = 1'b0;
    s_d.data_pointer16_wr = 1'b0;
    if (req_valid) begin
      s_d.pc_new = rel.target;
      s_d.taken = cond;
      case (op)
        ibx_pkg::IBX_OP_DEC_BR2, ibx_pkg::IBX_OP_DEC_BR3: begin
          s_d.wb_byte = dec_byte; // RL1
          s_d.wb_byte_en = 1'b1;
        end
        ibx_pkg::IBX_OP_INC: begin
          s_d.wb_byte = inc_byte; // RL2
          s_d.wb_byte_en = 1'b1;
        end
        ibx_pkg::IBX_OP_INC_DP: begin
          s_d.data_pointer16_new = data_pointer16 + ibx_pkg::WORD_ONE; // RL5
          s_d.data_pointer16_wr = 1'b1;
        end
        ibx_pkg::IBX_OP_BR_CLR_BIT: begin
          s_d.wb_bit_clear = bit_val; // RL9
        end
        ibx_pkg::IBX_OP_JMP: begin
          s_d.pc_new = {8'h00, acc} + data_pointer16; // RL15
          s_d.taken = 1'b1;
        end
        ibx_pkg::IBX_OP_NONE: begin
          s_d.unsupported = 1'b1;
          s_d.pc_new = pc;
        end
        default: s_d.unsupported = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{done: 1'b0, unsupported: 1'b0, taken: 1'b0, pc_new: ibx_pkg::PC_RESET,
               wb_byte: ibx_pkg::BYTE_ZERO, wb_byte_en: 1'b0, wb_bit_clear: 1'b0,
               data_pointer16_new: ibx_pkg::DP16_RESET, data_pointer16_wr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    done = s_q.done;
    unsupported = s_q.unsupported;
    taken = s_q.taken;
    pc_new = s_q.pc_new;
    wb_byte = s_q.wb_byte;
    wb_byte_en = s_q.wb_byte_en;
    wb_bit_clear = s_q.wb_bit_clear;
    data_pointer16_new = s_q.data_pointer16_new;
    data_pointer16_wr = s_q.data_pointer16_wr;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_dec_wrap;
    req_valid && op == ibx_pkg::IBX_OP_DEC_BR2 && rmw_byte == 8'h00 |=> wb_byte == 8'hFF && taken;
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("loop decrement wrap or branch wrong"); // RL1

  property p_inc_roll;
    req_valid && op == ibx_pkg::IBX_OP_INC && rmw_byte == 8'hFF |=> wb_byte_en && wb_byte == 8'h00;
  endproperty
  a_inc_roll: assert property (p_inc_roll) else $error("increment rollover wrong"); // RL2

  property p_inc_latch;
    req_valid && op == ibx_pkg::IBX_OP_INC && operand_is_port |=> wb_byte == $past(operand_latch) + 8'h01;
  endproperty
  a_inc_latch: assert property (p_inc_latch) else $error("port increment not from latch"); // RL4

  property p_dp_inc;
    req_valid && op == ibx_pkg::IBX_OP_INC_DP |=> data_pointer16_wr && data_pointer16_new == $past(data_pointer16) + 16'h0001;
  endproperty
  a_dp_inc: assert property (p_dp_inc) else $error("data pointer increment wrong"); // RL5

  property p_carry_target;
    req_valid && op == ibx_pkg::IBX_OP_BR_C |=>
      pc_new == $past(pc) + 16'h0002 + ($past(carry) ? {{8{$past(byte2[7])}}, $past(byte2)} : 16'h0000);
  endproperty
  a_carry_target: assert property (p_carry_target) else $error("carry branch target wrong"); // RL6

  property p_bitclr_target;
    req_valid && op == ibx_pkg::IBX_OP_BR_NSET && !bit_val |=>
      taken && !wb_bit_clear && pc_new == $past(pc) + 16'h0003 + {{8{$past(byte3[7])}}, $past(byte3)};
  endproperty
  a_bitclr_target: assert property (p_bitclr_target) else $error("bit-clear branch wrong"); // RL7

  property p_bitset_keep;
    req_valid && op == ibx_pkg::IBX_OP_BR_SET |=> !wb_bit_clear && !wb_byte_en && taken == $past(bit_val);
  endproperty
  a_bitset_keep: assert property (p_bitset_keep) else $error("bit-set branch wrong"); // RL8

  property p_brclr_clear;
    req_valid && op == ibx_pkg::IBX_OP_BR_CLR_BIT |=> wb_bit_clear == $past(bit_val) && taken == $past(bit_val);
  endproperty
  a_brclr_clear: assert property (p_brclr_clear) else $error("branch-and-clear wrong"); // RL9

  property p_bit_latch;
    req_valid && op == ibx_pkg::IBX_OP_BR_SET && bit_is_port |=> taken == $past(bit_latch);
  endproperty
  a_bit_latch: assert property (p_bit_latch) else $error("port bit not from latch"); // RL10

  property p_nocarry;
    req_valid && op == ibx_pkg::IBX_OP_BR_NC |=> taken == !$past(carry);
  endproperty
  a_nocarry: assert property (p_nocarry) else $error("no-carry branch wrong"); // RL13

  property p_accnz;
    req_valid && op == ibx_pkg::IBX_OP_BR_NZ |=> taken == ($past(acc) != 8'h00) && !wb_byte_en;
  endproperty
  a_accnz: assert property (p_accnz) else $error("accumulator branch wrong"); // RL14

  property p_jmp;
    req_valid && op == ibx_pkg::IBX_OP_JMP |=> pc_new == {8'h00, $past(acc)} + $past(data_pointer16);
  endproperty
  a_jmp: assert property (p_jmp) else $error("indexed jump target wrong"); // RL15

endmodule : ibx_exec

// ==== include/ibx_pkg.sv ====
/*
  Shared constants for the increment-and-branch executor: opcode patterns, instruction lengths,
  operation classes and reset values.
  Assumes a single core clock and a fetch stage that hands over whole instructions.
*/
package ibx_pkg;

  // fixed opcodes
  localparam logic [7:0] OPC_BR_CLR_BIT = 8'h10;
  localparam logic [7:0] OPC_BR_BIT_SET = 8'h20;
  localparam logic [7:0] OPC_BR_BIT_CLEAR = 8'h30;
  localparam logic [7:0] OPC_BR_CARRY = 8'h40;
  localparam logic [7:0] OPC_BR_NO_CARRY = 8'h50;
  localparam logic [7:0] OPC_BR_ACC_NZ = 8'h70;
  localparam logic [7:0] OPC_JMP_IDX = 8'h73;
  localparam logic [7:0] OPC_INC_DIR = 8'h05;
  localparam logic [7:0] OPC_DEC_BR_DIR = 8'hD5;

  // patterns matched under a mask
  localparam logic [7:0] MSK_REG = 8'hF8;
  localparam logic [7:0] MSK_PTR = 8'hFE;
  localparam logic [7:0] PAT_INC_REG = 8'h08;
  localparam logic [7:0] PAT_INC_PTR = 8'h06;
  localparam logic [7:0] PAT_DEC_BR_REG = 8'hD8;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] DP16_RESET = 16'h0000;

  typedef enum logic [3:0] {
    IBX_OP_NONE = 4'h0,
    IBX_OP_DEC_BR2 = 4'h1,
    IBX_OP_DEC_BR3 = 4'h2,
    IBX_OP_INC = 4'h3,
    IBX_OP_INC_DP = 4'h4,
    IBX_OP_BR_SET = 4'h5,
    IBX_OP_BR_CLR_BIT = 4'h6,
    IBX_OP_BR_NSET = 4'h7,
    IBX_OP_BR_C = 4'h8,
    IBX_OP_BR_NC = 4'h9,
    IBX_OP_BR_NZ = 4'hA,
    IBX_OP_JMP = 4'hB
  } ibx_op_t;

endpackage : ibx_pkg

// ==== include/ibx_rel_if.sv ====
/*
  Carrier between the executor and its relative-target adder.
  Assumes both ends sit on the same core clock; the adder is purely combinational.
*/
`timescale 1ns/10ps
interface ibx_rel_if;
  logic [15:0] pc_base;
  logic [7:0] disp;
  logic [1:0] len;
  logic take;
  logic [15:0] target;

  modport drv (output pc_base, output disp, output len, output take, input target);
  modport adder (input pc_base, input disp, input len, input take, output target);
endinterface : ibx_rel_if

// ==== core/ibx_reltgt.sv ====
/*
  Relative target adder: next sequential address, plus the sign-extended displacement when taken.
  Assumes the caller supplies the instruction's own address and byte length.
*/
`timescale 1ns/10ps
module ibx_reltgt (
  ibx_rel_if.adder rel
);
  logic [15:0] seq_pc;
  logic [15:0] disp_ext;

  always_comb begin
    // advance past the whole instruction first
    seq_pc = rel.pc_base + {14'h0000, rel.len}; // RL6 RL7
    disp_ext = {{8{rel.disp[7]}}, rel.disp}; // RL16
    rel.target = rel.take ? seq_pc + disp_ext : seq_pc; // RL6 RL7 RL16
  end
endmodule : ibx_reltgt

// ==== sim/tb_increment_and_branch_exec.sv ====
/*
  Self-checking bench for the increment-and-branch executor: table-driven and random instructions
  are compared against a behavioural integer model at every result.
  Assumes the executor answers one cycle after each accepted request and holds its wide results.
*/
`timescale 1ns/10ps
module tb_increment_and_branch_exec;
  localparam logic [7:0] DP_OPC = 8'hA3;
  localparam int NTAB = 29;
  logic clk, rst, req_valid, operand_is_port, bit_pin, bit_latch, bit_is_port, carry;
  logic [7:0] opcode, byte2, byte3, operand_pin, operand_latch, acc;
  logic [15:0] pc, data_pointer16, pc_new, data_pointer16_new;
  logic done, unsupported, taken, wb_byte_en, wb_bit_clear, data_pointer16_wr;
  logic [7:0] wb_byte;
  logic [7:0] tab [NTAB] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
    8'hA3, 8'hD5, 8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF,
    8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h70, 8'h73, 8'h04};
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int armed = 0;
  int e_done, e_tk, e_un, e_wbe, e_clr, e_dpw, e_pc, e_wb, e_dp;
  int pc_q[$];

  ibx_exec #(.OPC_INC_DP(DP_OPC)) ibx_exec_i (
    .clk(clk), .rst(rst), .req_valid(req_valid), .opcode(opcode), .byte2(byte2), .byte3(byte3),
    .pc(pc), .operand_pin(operand_pin), .operand_latch(operand_latch), .operand_is_port(operand_is_port),
    .bit_pin(bit_pin), .bit_latch(bit_latch), .bit_is_port(bit_is_port), .carry(carry), .acc(acc),
    .data_pointer16(data_pointer16), .done(done), .unsupported(unsupported), .taken(taken),
    .pc_new(pc_new), .wb_byte(wb_byte), .wb_byte_en(wb_byte_en), .wb_bit_clear(wb_bit_clear),
    .data_pointer16_new(data_pointer16_new), .data_pointer16_wr(data_pointer16_wr)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // boundary values are favoured so that wraps and sign changes occur often
  function automatic logic [7:0] edge8();
    int r;
    r = $urandom % 8;
    return r == 0 ? 8'hFF : r == 1 ? 8'h00 : r == 2 ? 8'h7F : r == 3 ? 8'h80 : r == 4 ? 8'h01 : 8'($urandom);
  endfunction : edge8

  // behavioural model: expectations for the answer due one edge later
  always @(posedge clk) begin : model
    int v;
    int b;
    int len;
    int t;
    armed = armed | rst;
    e_done = 0; e_tk = 0; e_un = 0; e_wbe = 0; e_clr = 0; e_dpw = 0;
    if (rst) begin
      e_pc = 0; e_wb = 0; e_dp = 0;
    end else if (req_valid) begin
      e_done = 1;
      v = operand_is_port ? operand_latch : operand_pin;
      b = bit_is_port ? bit_latch : bit_pin;
      len = 1;
      t = 0;
      if (opcode == 8'h05 || opcode[7:3] == 5'h01 || opcode[7:1] == 7'h03) begin
        len = (opcode == 8'h05) ? 2 : 1;
        e_wb = (v + 1) & 255; e_wbe = 1;
      end else if (opcode == 8'hD5 || opcode[7:3] == 5'h1B) begin
        len = (opcode == 8'hD5) ? 3 : 2;
        e_wb = (v + 255) & 255; e_wbe = 1; t = (e_wb != 0);
      end else if (opcode == DP_OPC) begin
        e_dp = (data_pointer16 + 1) & 65535; e_dpw = 1;
      end else if (opcode inside {8'h10, 8'h20, 8'h30}) begin
        len = 3; t = (opcode == 8'h30) ? !b : b; e_clr = (opcode == 8'h10) && b;
      end else if (opcode inside {8'h40, 8'h50, 8'h70}) begin
        len = 2; t = (opcode == 8'h40) ? carry : (opcode == 8'h50) ? !carry : (acc != 0);
      end else if (opcode != 8'h73) begin
        len = 0; e_un = 1;
      end
      e_tk = t;
      e_pc = pc + len + (t ? (((len == 3) ? byte3 : byte2) ^ 128) - 128 : 0);
      if (opcode == 8'h73) begin
        e_tk = 1; e_pc = acc + data_pointer16;
      end
      e_pc = e_pc & 65535;
    end
    pc_q.push_back(e_pc);
  end

  always @(negedge clk) begin
    if (armed != 0) begin
      check(16'(done), 16'(e_done));
      check(16'(unsupported), 16'(e_un));
      check(16'(taken), 16'(e_tk));
      check(pc_new, 16'(pc_q.pop_front()));
      check(16'(wb_byte), 16'(e_wb));
      check(16'(wb_byte_en), 16'(e_wbe));
      check(16'(wb_bit_clear), 16'(e_clr));
      check(data_pointer16_new, 16'(e_dp));
      check(16'(data_pointer16_wr), 16'(e_dpw));
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    logic [7:0] op;
    int seed;
    rst = 1'b1; req_valid = 1'b0; opcode = 8'h00; byte2 = 8'h00; byte3 = 8'h00; pc = 16'h0000;
    operand_pin = 8'h00; operand_latch = 8'h00; operand_is_port = 1'b0; bit_pin = 1'b0;
    bit_latch = 1'b0; bit_is_port = 1'b0; carry = 1'b0; acc = 8'h00; data_pointer16 = 16'h0000;
    seed = $urandom(36093);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // table first so every opcode is seen, then a random mix with a reset in mid-run
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      op = (i < NTAB) ? tab[i] : ($urandom % 4 == 0) ? 8'($urandom) : tab[$urandom % NTAB];
      req_valid <= (i < NTAB) || ($urandom % 5 != 0);
      rst <= (i == 300);
      opcode <= op;
      byte2 <= edge8();
      byte3 <= edge8();
      operand_pin <= edge8();
      operand_latch <= edge8();
      acc <= edge8();
      pc <= {edge8(), edge8()};
      data_pointer16 <= {edge8(), edge8()};
      {operand_is_port, bit_pin, bit_latch, bit_is_port, carry} <= 5'($urandom);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule : tb_increment_and_branch_exec
